// *** rtl/cmvd_top.sv ***
// move instruction decode and execution sequencing
// Function
// - long move: first cycle idle, second reads, third writes, no dummy read
// - opcode 0000 0001 00 loads six-bit literal into bank select bits 5..0
// - bank select bits 7 and 6 always read zero
// - bank-select load: decode, fetch literal, process, write at Q4
// - opcode upper byte 0000 1110 loads literal into working register at Q4
// - opcode 0110 111 stores working register into addressed bank byte
// - extended set, access clear, address at most 95: indexed literal offset
// - these instructions leave all status flags unchanged
// - store reads working register at Q2, writes target at Q4
`timescale 1ns/1ps
`include "cmvd_defs.svh"
module cmvd_top
  import cmvd_pkg::*;
(
  input wire logic clk_i, // 200 MHz core clock
  input wire logic rst_b_i, // asynchronous reset, active low
  input wire logic [15:0] instr_i, // instruction word, valid at Q1
  input wire logic ext_en_i, // extended instruction set enable pin
  input wire logic [13:0] fsr2_i, // index base for literal offset mode
  input wire logic [7:0] dmem_rdata_i, // data memory read data
  output cmvd_pkg::cmvd_dmem_req_type dmem_req_o, // data memory request
  output logic [7:0] w_o, // working register
  output logic [7:0] bsr_o, // bank select register
  output logic status_we_o, // status flag write strobe
  output logic other_op_o, // opcode handed to other decoders
  output logic [15:0] other_instr_o // the handed-over opcode
);

  // ****************************************************************
  // reset and pin synchronisers
  // ****************************************************************
  logic rst_s1_q;
  logic rst_b;
  logic ext_s1_q;
  logic ext_q;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_s1_q <= 1'b0;
      rst_b <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_b <= rst_s1_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_s1_q <= 1'b0;
      ext_q <= 1'b0;
    end
    else
    begin
      ext_s1_q <= ext_en_i;
      ext_q <= ext_s1_q;
    end
  end

  // ****************************************************************
  // phase sequencer
  // ****************************************************************
  cmvd_phase_type phase;

  cmvd_quarter u_quarter (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .phase_o(phase)
  );

  // ****************************************************************
  // decode
  // ****************************************************************
  logic [15:0] ir_q;
  logic [7:0] w_q;
  logic [5:0] bsr_q;
  logic [7:0] opnd_q;
  logic [13:0] addr_q;
  logic [13:0] fs_q;
  logic [1:0] fd_hi_q;
  logic [7:0] data_q;
  cmvd_state_type st_q;
  cmvd_dmem_req_type req_q;
  logic other_q;
  logic [15:0] oinstr_q;

  wire is_bsl = ir_q[15:6] == `CMVD_OP_BSL;
  wire is_lwl = ir_q[15:8] == `CMVD_OP_LWL;
  wire is_wfs = ir_q[15:9] == `CMVD_OP_WFS;
  wire is_ffl1 = ir_q[15:4] == `CMVD_OP_FFL1;
  wire is_fflx = ir_q[15:12] == `CMVD_OP_FFLX;
  wire any_op = is_bsl | is_lwl | is_wfs | is_ffl1;
  wire single = st_q == CMVD_ST_SINGLE;

  wire [7:0] fadr = ir_q[7:0];
  wire acc_sel = ir_q[`CMVD_ACC_BIT];
  wire low_f = fadr <= `CMVD_ILO_MAX;
  wire use_ilo = ext_q & ~acc_sel & low_f;
  wire [13:0] ilo_addr = fsr2_i + {6'h00, fadr};
  wire [5:0] acc_bank = low_f ? `CMVD_ACC_LO_BANK : `CMVD_ACC_HI_BANK;
  wire [13:0] acc_addr = {acc_bank, fadr};
  wire [13:0] bank_addr = {bsr_q, fadr};
  wire [13:0] wfs_addr = acc_sel ? bank_addr :
                         (use_ilo ? ilo_addr : acc_addr);
  wire [13:0] fs_addr = {fs_q[13:10], ir_q[11:2]};
  wire [13:0] fd_addr = {fd_hi_q, ir_q[11:0]};

  // ****************************************************************
  // execution over the quarter phases
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ir_q <= `CMVD_IR_RST;
      w_q <= `CMVD_W_RST;
      bsr_q <= `CMVD_BSR_RST;
      opnd_q <= 8'h00;
      addr_q <= 14'h0000;
      fs_q <= 14'h0000;
      fd_hi_q <= 2'h0;
      data_q <= 8'h00;
      st_q <= CMVD_ST_SINGLE;
      req_q <= '0;
      other_q <= 1'b0;
      oinstr_q <= 16'h0000;
    end
    else
    begin
      unique case (phase)
        CMVD_Q1:
        begin
          ir_q <= instr_i;
          req_q.we <= 1'b0;
          other_q <= 1'b0;
        end
        CMVD_Q2:
        begin
          if (single)
          begin
            opnd_q <= is_wfs ? w_q : ir_q[7:0];
          end
          else if (st_q == CMVD_ST_FFL_W2 && is_fflx)
          begin
            fd_hi_q <= ir_q[1:0];
            req_q.addr <= fs_addr;
            req_q.rd <= 1'b1;
          end
        end
        CMVD_Q3:
        begin
          req_q.rd <= 1'b0;
          if (st_q == CMVD_ST_FFL_W2)
          begin
            data_q <= dmem_rdata_i;
          end
          addr_q <= wfs_addr;
        end
        CMVD_Q4:
        begin
          unique case (st_q)
            CMVD_ST_SINGLE:
            begin
              if (is_bsl)
              begin
                bsr_q <= ir_q[`CMVD_BSL_MSB:0];
              end
              if (is_lwl)
              begin
                w_q <= ir_q[`CMVD_LIT_MSB:0];
              end
              if (is_wfs)
              begin
                req_q.addr <= addr_q;
                req_q.wdata <= opnd_q;
                req_q.we <= 1'b1;
              end
              if (is_ffl1)
              begin
                fs_q[13:10] <= ir_q[3:0];
                st_q <= CMVD_ST_FFL_W2;
              end
              if (!any_op)
              begin
                other_q <= 1'b1;
                oinstr_q <= ir_q;
              end
            end
            CMVD_ST_FFL_W2:
            begin
              st_q <= is_fflx ? CMVD_ST_FFL_W3 : CMVD_ST_SINGLE;
            end
            CMVD_ST_FFL_W3:
            begin
              if (is_fflx)
              begin
                req_q.addr <= fd_addr;
                req_q.wdata <= data_q;
                req_q.we <= 1'b1;
              end
              st_q <= CMVD_ST_SINGLE;
            end
            default:
            begin
              st_q <= CMVD_ST_SINGLE;
            end
          endcase
        end
      endcase
    end
  end

  // status flags are never written by this group
  logic status_q;

  always_ff @(posedge clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_q <= 1'b0;
    end
    else
    begin
      status_q <= 1'b0;
    end
  end

  assign dmem_req_o = req_q;
  assign w_o = w_q;
  assign bsr_o = {2'b00, bsr_q};
  assign status_we_o = status_q;
  assign other_op_o = other_q;
  assign other_instr_o = oinstr_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b);

  bsr_top_zero_a: assert property (bsr_o[7:6] == 2'b00)
    else $error("bank select top bits not zero");

  bsl_load_a: assert property (phase == CMVD_Q4 && single && is_bsl
    |=> bsr_o == {2'b00, $past(ir_q[5:0])})
    else $error("bank select load wrong");

  bsl_timing_a: assert property (phase != CMVD_Q4 |=> $stable(bsr_o))
    else $error("bank select changed outside fourth quarter");

  lwl_load_a: assert property (phase == CMVD_Q4 && single && is_lwl
    |=> w_o == $past(ir_q[7:0]))
    else $error("working register literal load wrong");

  wfs_store_a: assert property (phase == CMVD_Q4 && single && is_wfs
    |=> dmem_req_o.we && dmem_req_o.wdata == w_o ##1 !dmem_req_o.we)
    else $error("working register store wrong");

  wfs_read_a: assert property (phase == CMVD_Q2 && single && is_wfs
    |=> opnd_q == $past(w_q))
    else $error("working register not read in second quarter");

  wfs_bank_a: assert property (phase == CMVD_Q3 && is_wfs && acc_sel
    |=> addr_q == {$past(bsr_q), $past(fadr)})
    else $error("banked store address wrong");

  wfs_index_a: assert property (phase == CMVD_Q3 && is_wfs && use_ilo
    |=> addr_q == $past(ilo_addr))
    else $error("indexed store address wrong");

  ffl_noread_a: assert property (st_q == CMVD_ST_FFL_W3
    |-> !dmem_req_o.rd)
    else $error("dummy read in long move write cycle");

  ffl_idle_a: assert property (phase == CMVD_Q4 && single && is_ffl1
    |=> !dmem_req_o.we [*4])
    else $error("long move acted in first cycle");

  status_none_a: assert property (!status_we_o)
    else $error("status written");

  other_pass_a: assert property (phase == CMVD_Q4 && single && !any_op
    |=> other_op_o && $stable(w_o) && $stable(bsr_o) && !dmem_req_o.we)
    else $error("unmatched opcode changed state");

  bsl_seen_c: cover property (phase == CMVD_Q4 && single && is_bsl);
  wfs_ilo_c: cover property (phase == CMVD_Q3 && is_wfs && use_ilo);
  ffl_write_c: cover property (st_q == CMVD_ST_FFL_W3 ##3 dmem_req_o.we);
  other_c: cover property (other_op_o);

endmodule // cmvd_top

// *** rtl/cmvd_defs.svh ***
// offsets, field positions, opcode patterns and reset values of the decoder
`ifndef CMVD_DEFS_SVH
`define CMVD_DEFS_SVH

// opcode patterns, compared against the top bits of the instruction word
`define CMVD_OP_BSL 10'h004
`define CMVD_OP_LWL 8'h0E
`define CMVD_OP_WFS 7'h37
`define CMVD_OP_FFL1 12'h006
`define CMVD_OP_FFLX 4'hF

// field positions
`define CMVD_ACC_BIT 8
`define CMVD_BSL_MSB 5
`define CMVD_LIT_MSB 7

// addressing
`define CMVD_ILO_MAX 8'h5F
`define CMVD_ACC_LO_BANK 6'h00
`define CMVD_ACC_HI_BANK 6'h3F

// reset values
`define CMVD_W_RST 8'h00
`define CMVD_BSR_RST 6'h00
`define CMVD_IR_RST 16'h0000

`endif

// *** rtl/cmvd_pkg.sv ***
// types shared by the move instruction decoder
package cmvd_pkg;

  // quarter phases of one instruction cycle, gray coded
  typedef enum logic [1:0] {
    CMVD_Q1 = 2'b00,
    CMVD_Q2 = 2'b01,
    CMVD_Q3 = 2'b11,
    CMVD_Q4 = 2'b10
  } cmvd_phase_type;

  // sequencing state; the long move walks single, word two, word three
  typedef enum logic [1:0] {
    CMVD_ST_SINGLE = 2'b00,
    CMVD_ST_FFL_W2 = 2'b01,
    CMVD_ST_FFL_W3 = 2'b11
  } cmvd_state_type;

  // data memory request
  typedef struct packed {
    logic [13:0] addr;
    logic rd;
    logic we;
    logic [7:0] wdata;
  } cmvd_dmem_req_type;

endpackage

// *** rtl/cmvd_quarter.sv ***
// quarter phase sequencer of the instruction clock
`timescale 1ns/1ps
module cmvd_quarter
  import cmvd_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic rst_b_i, // synchronised reset, active low
  output cmvd_pkg::cmvd_phase_type phase_o // current quarter phase
);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      phase_o <= CMVD_Q1;
    end
    else
    begin
      unique case (phase_o)
        CMVD_Q1: phase_o <= CMVD_Q2;
        CMVD_Q2: phase_o <= CMVD_Q3;
        CMVD_Q3: phase_o <= CMVD_Q4;
        CMVD_Q4: phase_o <= CMVD_Q1;
      endcase
    end
  end

endmodule // cmvd_quarter

// *** tb/cpu_move_instruction_decode_tb.sv ***
// self-checking bench of the move instruction decoder
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module cpu_move_instruction_decode_tb;
  import cmvd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i, ext_en_i, status_we_o, other_op_o;
  logic [15:0] instr_i, other_instr_o;
  logic [13:0] fsr2_i;
  logic [7:0] dmem_rdata_i, w_o, bsr_o, w_m, bsr_m, src;
  cmvd_pkg::cmvd_dmem_req_type dmem_req_o;
  logic [21:0] wq[$], exp_w;
  logic [13:0] rq[$], lfs, lfd, exp_r;
  logic [15:0] oq[$], exp_o;
  int error_cnt, comparisons, cyc, lm, i;
  logic hold;
  integer seed;

  cmvd_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .instr_i(instr_i),
    .ext_en_i(ext_en_i), .fsr2_i(fsr2_i), .dmem_rdata_i(dmem_rdata_i),
    .dmem_req_o(dmem_req_o), .w_o(w_o), .bsr_o(bsr_o),
    .status_we_o(status_we_o), .other_op_o(other_op_o),
    .other_instr_o(other_instr_o));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ****************************
  // source data: held through the long move's read and write cycles, else noise
  // ****************************
  always @(posedge clk_i)
  begin
    dmem_rdata_i <= hold ? src : 8'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  // ****************************
  // monitor: pops the oldest expectation whenever a result appears
  // ****************************
  always @(negedge clk_i)
  begin
    `CHK(status_we_o, 1'b0)
    `CHK(w_o, w_m)
    `CHK(bsr_o, bsr_m)
    `CHK(bsr_o[7:6], 2'b00)
    if (dmem_req_o.we)
    begin
      `CHK(wq.size() > 0, 1'b1)
      if (wq.size() > 0)
      begin
        exp_w = wq.pop_front();
        `CHK({dmem_req_o.addr, dmem_req_o.wdata}, exp_w)
      end
    end
    if (dmem_req_o.rd)
    begin
      `CHK(rq.size() > 0, 1'b1)
      if (rq.size() > 0)
      begin
        exp_r = rq.pop_front();
        `CHK(dmem_req_o.addr, exp_r)
      end
    end
    if (other_op_o)
    begin
      `CHK(oq.size() > 0, 1'b1)
      if (oq.size() > 0)
      begin
        exp_o = oq.pop_front();
        `CHK(other_instr_o, exp_o)
      end
    end
  end

  // one word per instruction cycle; notes what it should cause
  task automatic issue(input logic [15:0] w);
    logic [7:0] f;
    logic [13:0] a;
    f = w[7:0];
    instr_i <= w;
    // a later long move word without the top nibble aborts the move
    if (lm != 0 && w[15:12] != 4'hF)
      lm = 0;
    else if (lm == 1)
    begin
      lfs[9:0] = w[11:2];
      lfd[13:12] = w[1:0];
      src = 8'($random(seed));
      hold = 1'b1;
      rq.push_back(lfs);
      lm = 2;
    end
    else if (lm == 2)
    begin
      lfd[11:0] = w[11:0];
      wq.push_back({lfd, src});
      lm = 0;
    end
    else if (w[15:4] == 12'h006)
    begin
      lfs[13:10] = w[3:0];
      lm = 1;
    end
    else if (w[15:9] == 7'h37)
    begin
      if (w[8])
        a = {bsr_m[5:0], f};
      else if (ext_en_i && f <= 8'h5F)
        a = 14'(fsr2_i + {6'h00, f});
      else
        a = (f <= 8'h5F) ? {6'h00, f} : {6'h3F, f};
      wq.push_back({a, w_m});
    end
    else if (w[15:6] != 10'h004 && w[15:8] != 8'h0E)
      oq.push_back(w);
    repeat (4) @(posedge clk_i);
    if (lm == 0)
      hold = 1'b0;
    if (w[15:6] == 10'h004 && lm == 0)
      bsr_m = {2'b00, w[5:0]};
    if (w[15:8] == 8'h0E && lm == 0)
      w_m = f;
  endtask

  task automatic stores(input int n);
    for (int k = 0; k < n; k++)
    begin
      issue({8'h0E, 8'($random(seed))});
      issue({7'h37, 1'($random(seed)), 8'($random(seed))});
    end
    issue(16'h6E5F);
    issue(16'h6E60);
    issue(16'h6E00);
    issue(16'h6FFF);
  endtask

  task automatic wrap_up();
    `CHK(wq.size() + rq.size() + oq.size(), 0)
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    seed = 32'ha18e_e880;
    rst_b_i = 1'b0;
    instr_i = 16'h0000;
    ext_en_i = 1'b0;
    fsr2_i = 14'h0000;
    w_m = 8'h00;
    bsr_m = 8'h00;
    hold = 1'b0;
    lm = 0;
    error_cnt = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    for (i = 0; i < 8; i++)
      issue({8'h0E, 8'($random(seed))});
    $display("test literal load done");
    issue(16'h0105);
    issue(16'h013F);
    for (i = 0; i < 6; i++)
      issue({10'h004, 6'($random(seed))});
    $display("test bank select load done");
    stores(12);
    $display("test store access bank done");
    ext_en_i <= 1'b1;
    fsr2_i <= 14'($random(seed));
    issue(16'h0000);
    stores(12);
    ext_en_i <= 1'b0;
    issue(16'h0000);
    $display("test store indexed done");
    issue(16'h0D12);
    issue(16'h6C20);
    issue(16'h0140);
    issue(16'h0F00);
    issue(16'h6D00);
    issue(16'hFFFF);
    issue(16'h0010);
    $display("test unmatched done");
    for (i = 0; i < 3; i++)
    begin
      lfs = 14'($random(seed));
      lfd = 14'($random(seed));
      issue({12'h006, lfs[13:10]});
      issue({4'hF, lfs[9:0], lfd[13:12]});
      issue({4'hF, lfd[11:0]});
    end
    issue(16'h6E10);
    issue(16'h0065);
    issue(16'h6C20);
    issue(16'h0063);
    issue(16'hF123);
    issue(16'h6C20);
    issue(16'h0000);
    issue(16'h0000);
    $display("test long move done");
    repeat (2) @(posedge clk_i);
    wrap_up();
  end
endmodule // cpu_move_instruction_decode_tb
